// ==== brf_defs.svh ====
// constants for the banked register file pointer block
`ifndef BRF_DEFS_SVH
`define BRF_DEFS_SVH
`define BRF_ADDR_PTR 8'hfd
`define BRF_ADDR_SCRATCH 8'hfe
`define BRF_ADDR_STACK 8'hff
`define BRF_PTR_RESET 8'h00
`define BRF_GRP_MSB 7
`define BRF_GRP_LSB 4
`define BRF_BANK_MSB 3
`define BRF_BANK_LSB 0
`define BRF_WORK_BASE 4'he
`define BRF_CTRL_BASE 4'hf
`define BRF_SRC_BIT 7
`define BRF_GPR_LO 8'h04
`define BRF_GPR_B0_HI 8'h0f
`define BRF_GPR_HI 8'hef
`define BRF_CTRL_LO 8'hf0
`define BRF_CTRL_HI 8'hfa
`endif

// ==== brf_pkg.sv ====
// types for the banked register file pointer block
package brf_pkg;
   typedef enum logic [1:0] {
      BRF_ST_IDLE,
      BRF_ST_PUSH_LO,
      BRF_ST_PUSH_HI,
      BRF_ST_FLAGS
   } brf_stk_state_t;
   typedef enum logic [1:0] {
      BRF_OP_NONE,
      BRF_OP_CALL,
      BRF_OP_IRQ,
      BRF_OP_POP
   } brf_stk_op_t;
endpackage

// ==== brf_map_if.sv ====
// operand mapping signals between the top and its address mapper
`timescale 1ns/10ps
interface brf_map_if;
   logic [7:0] ptr;
   logic [7:0] addr8;
   logic is_work;
   logic [11:0] lin;
   logic [2:0] region;
   modport top (output ptr, output addr8, output is_work, input lin, input region);
   modport map (input ptr, input addr8, input is_work, output lin, output region);
endinterface

// ==== brf_addr_map.sv ====
// linear address mapping of 8-bit and 4-bit operands
`timescale 1ns/10ps
`include "brf_defs.svh"
module brf_addr_map (
   brf_map_if.map m
);
   // ----------------------------------------
   // mapping
   // ----------------------------------------
   logic [7:0] a;
   logic [3:0] bank;
   always_comb begin
      bank = m.ptr[`BRF_BANK_MSB:`BRF_BANK_LSB]; // RULE2
      // working operand: group from upper nibble
      if (m.is_work) begin
         a = {m.ptr[`BRF_GRP_MSB:`BRF_GRP_LSB], m.addr8[3:0]}; // RULE1
         if (m.addr8[7:4] == `BRF_WORK_BASE) begin
            a = {`BRF_CTRL_BASE, m.addr8[3:0]}; // RULE19
         end
      end else begin
         a = m.addr8;
      end
      // region code: 0 port,1 bank0 only,2 shared,3 ctrl,4 banked,5 reserved
      if (a >= `BRF_CTRL_LO) begin
         m.lin = {4'h0, a}; // RULE18 RULE19
         m.region = 3'h3;
      end else if (bank == 4'h0) begin
         m.lin = {4'h0, a}; // RULE3
         m.region = (a < `BRF_GPR_LO) ? 3'h0 : (a <= `BRF_GPR_B0_HI) ? 3'h1 : 3'h2; // RULE16
      end else if (bank == 4'hd || bank == 4'hf) begin
         // only low 16 are banked; 10..ef fall to bank 0
         m.lin = (a[7:4] == 4'h0) ? {bank, a} : {4'h0, a}; // RULE17
         m.region = (a[7:4] == 4'h0) ? 3'h4 : 3'h2;
      end else if (bank <= 4'h3) begin
         // expanded bank replaces locations 04-0F; 00-03 stay in bank 0
         m.lin = (a[7:4] == 4'h0 && a >= `BRF_GPR_LO) ? {bank, a} : {4'h0, a}; // RULE3 RULE21
         m.region = (a < `BRF_GPR_LO) ? 3'h0 : 3'h4;
      end else begin
         m.lin = {bank, a}; // RULE21
         m.region = 3'h5;
      end
   end
endmodule // brf_addr_map

// ==== brf_top.sv ====
// bank pointer, scratch byte and stack address registers
//
// What the document requires of this block and its software
// RULE1: upper pointer nibble picks working group
// RULE2: lower nibble picks bank; 0,1,2,3,D,F exist
// RULE3: zero means bank 0; else low 16 swapped (banks 1-3 swap only 004-00F here)
// RULE4: pointer read/write, resets zero, bank independent
// RULE5: scratch byte read/write, undefined at reset
// RULE6: software avoids scratch as loop counter
// RULE7: stack address register, stack in bank 0
// RULE8: push decrements then writes
// RULE9: pop reads then increments
// RULE10: stack address marks most recent item
// RULE11: call pushes program counter
// RULE12: interrupt pushes counter and flags
// RULE13: software prevents stack wrap
// RULE14: excluded bits survive stop recovery reset
// RULE15: stop recovery sets recovery control top bit
// RULE16: 004-00F general registers only in bank 0
// RULE17: 010-0EF reach bank 0 in 0,D,F
// RULE18: 0F0-0FA reachable from every bank
// RULE19: F0-FF always reach bank 0 controls
// RULE20: stack accesses always address bank 0
// RULE21: linear address is bank then offset
// RULE22: pointer write applies from next instruction
`timescale 1ns/10ps
`include "brf_defs.svh"
module brf_top (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // stop recovery reset pulse
   input wire logic stop_recov,
   // register access from cpu
   input wire logic reg_wr,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // operand mapping request
   input wire logic insn_start,
   input wire logic op_is_work,
   input wire logic [7:0] op_addr,
   output logic [11:0] op_lin,
   output logic [2:0] op_region,
   // stack requests
   input wire brf_pkg::brf_stk_op_t stk_op,
   input wire logic [15:0] pc_in,
   input wire logic [7:0] flags_in,
   output logic stk_busy,
   output logic stk_we,
   output logic [11:0] stk_addr,
   output logic [7:0] stk_wdata,
   output logic [7:0] stk_ptr,
   // recovery control top bit
   output logic recov_flag
);
   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [7:0] ptr_r; // bank and group pointer
   logic [7:0] ptr_act_r; // pointer seen by operand mapping
   logic [7:0] scratch_r; // user byte
   logic [7:0] sp_r; // stack address
   logic [7:0] sp_nxt;
   brf_pkg::brf_stk_state_t st_r;
   brf_pkg::brf_stk_state_t st_nxt;
   logic irq_r; // interrupt frame in progress
   logic sp_wr_ok; // stack address write accepted
   brf_map_if mi ();

   // write strobe aimed at one register address
   function automatic logic wr_hit(
      input logic wr,
      input logic [7:0] addr,
      input logic [7:0] want
   );
      return wr && (addr == want);
   endfunction

   // pointer register: reset to zero, stop recovery keeps it
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ptr_r <= `BRF_PTR_RESET; // RULE4
      end else if (wr_hit(reg_wr, reg_addr, `BRF_ADDR_PTR)) begin
         ptr_r <= reg_wdata; // RULE4 RULE14
      end
   end

   // active copy updates at instruction boundary
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ptr_act_r <= `BRF_PTR_RESET;
      end else if (insn_start) begin
         ptr_act_r <= ptr_r; // RULE22
      end
   end

   // scratch byte, no reset value
   always_ff @(posedge clk) begin
      if (wr_hit(reg_wr, reg_addr, `BRF_ADDR_SCRATCH)) begin
         scratch_r <= reg_wdata; // RULE5
      end
   end

   // recovery flag: cleared by reset, set by stop recovery
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         recov_flag <= 1'b0;
      end else if (stop_recov) begin
         recov_flag <= 1'b1; // RULE15
      end
   end

   // ----------------------------------------
   // stack sequencing
   // ----------------------------------------
   // frame layout, highest address first: pc low, pc high, then flags
   // for an interrupt; the pointer ends on the last byte pushed.
   // nothing guards against wrap, software keeps the stack in range
   always_comb begin
      sp_nxt = sp_r;
      st_nxt = st_r;
      case (st_r)
         brf_pkg::BRF_ST_IDLE: begin
            if (stk_op == brf_pkg::BRF_OP_CALL || stk_op == brf_pkg::BRF_OP_IRQ) begin
               sp_nxt = sp_r - 8'h01; // RULE8
               st_nxt = brf_pkg::BRF_ST_PUSH_LO; // RULE11 RULE12
            end else if (stk_op == brf_pkg::BRF_OP_POP) begin
               sp_nxt = sp_r + 8'h01; // RULE9
            end
         end
         brf_pkg::BRF_ST_PUSH_LO: begin
            sp_nxt = sp_r - 8'h01; // RULE8
            st_nxt = brf_pkg::BRF_ST_PUSH_HI;
         end
         brf_pkg::BRF_ST_PUSH_HI: begin
            if (irq_r) begin
               sp_nxt = sp_r - 8'h01; // RULE12
               st_nxt = brf_pkg::BRF_ST_FLAGS;
            end else begin
               st_nxt = brf_pkg::BRF_ST_IDLE;
            end
         end
         default: begin
            st_nxt = brf_pkg::BRF_ST_IDLE;
         end
      endcase
   end

   // stack sequencer state and interrupt frame flag
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_r <= brf_pkg::BRF_ST_IDLE;
         irq_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         if (st_r == brf_pkg::BRF_ST_IDLE) begin
            irq_r <= (stk_op == brf_pkg::BRF_OP_IRQ);
         end
      end
   end

   // stack address write accepted only while the sequencer rests
   assign sp_wr_ok = wr_hit(reg_wr, reg_addr, `BRF_ADDR_STACK)
      && st_r == brf_pkg::BRF_ST_IDLE;

   // stack address has no reset value; register writes win when idle
   always_ff @(posedge clk) begin
      if (sp_wr_ok) begin
         sp_r <= reg_wdata; // RULE7
      end else begin
         sp_r <= sp_nxt; // RULE10
      end
   end

   // stack memory strobe: write at already-decremented address
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         stk_we <= 1'b0;
         stk_addr <= 12'h000;
         stk_wdata <= 8'h00;
      end else begin
         stk_we <= (st_r != brf_pkg::BRF_ST_IDLE);
         stk_addr <= {4'h0, sp_r}; // RULE20 RULE8
         case (st_r)
            brf_pkg::BRF_ST_PUSH_LO: stk_wdata <= pc_in[7:0]; // RULE11
            brf_pkg::BRF_ST_PUSH_HI: stk_wdata <= pc_in[15:8]; // RULE11
            brf_pkg::BRF_ST_FLAGS: stk_wdata <= flags_in; // RULE12
            default: stk_wdata <= 8'h00;
         endcase
         if (st_r == brf_pkg::BRF_ST_IDLE && stk_op == brf_pkg::BRF_OP_POP) begin
            stk_addr <= {4'h0, sp_r}; // RULE9 RULE20
         end
      end
   end

   // busy and visible stack address
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         stk_busy <= 1'b0;
         stk_ptr <= 8'h00;
      end else begin
         stk_busy <= (st_nxt != brf_pkg::BRF_ST_IDLE);
         // a register write shows at once, not one cycle late
         if (sp_wr_ok) begin
            stk_ptr <= reg_wdata; // RULE10
         end else begin
            stk_ptr <= sp_nxt; // RULE10
         end
      end
   end

   // ----------------------------------------
   // register read and operand mapping
   // ----------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= 8'h00;
      end else if (reg_addr == `BRF_ADDR_PTR) begin
         reg_rdata <= ptr_r; // RULE4
      end else if (reg_addr == `BRF_ADDR_SCRATCH) begin
         reg_rdata <= scratch_r; // RULE5
      end else if (reg_addr == `BRF_ADDR_STACK) begin
         reg_rdata <= sp_r; // RULE7
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   assign mi.ptr = ptr_act_r;
   assign mi.addr8 = op_addr;
   assign mi.is_work = op_is_work;

   brf_addr_map u_map (
      .m(mi)
   );

   // registered mapping result
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         op_lin <= 12'h000;
         op_region <= 3'h0;
      end else begin
         op_lin <= mi.lin; // RULE16 RULE17 RULE18 RULE21
         op_region <= mi.region;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_ptr_reset_zero: assert property (@(posedge clk) $rose(resetn) |-> ptr_r == 8'h00) // RULE4
      else $error("pointer not zero after reset");
   a_ptr_write_store: assert property (@(posedge clk) disable iff (!resetn)
      reg_wr && reg_addr == 8'hfd |=> ptr_r == $past(reg_wdata)) // RULE4
      else $error("pointer write lost");
   a_ptr_next_insn: assert property (@(posedge clk) disable iff (!resetn)
      insn_start |=> ptr_act_r == $past(ptr_r)) // RULE22
      else $error("active pointer not updated");
   a_push_decrement: assert property (@(posedge clk) disable iff (!resetn)
      st_r == brf_pkg::BRF_ST_IDLE && stk_op == brf_pkg::BRF_OP_CALL && !reg_wr
      |=> sp_r == $past(sp_r) - 8'h01) // RULE8
      else $error("push did not decrement first");
   a_pop_increment: assert property (@(posedge clk) disable iff (!resetn)
      st_r == brf_pkg::BRF_ST_IDLE && stk_op == brf_pkg::BRF_OP_POP && !reg_wr
      |=> sp_r == $past(sp_r) + 8'h01 && stk_addr == {4'h0, $past(sp_r)}) // RULE9
      else $error("pop address or increment wrong");
   a_call_two_bytes: assert property (@(posedge clk) disable iff (!resetn)
      st_r == brf_pkg::BRF_ST_IDLE && stk_op == brf_pkg::BRF_OP_CALL
      |=> ##1 stk_we ##1 stk_we ##1 !stk_we) // RULE11
      else $error("call push length wrong");
   a_irq_three_bytes: assert property (@(posedge clk) disable iff (!resetn)
      st_r == brf_pkg::BRF_ST_IDLE && stk_op == brf_pkg::BRF_OP_IRQ
      |=> ##1 stk_we [*3] ##1 !stk_we) // RULE12
      else $error("interrupt push length wrong");
   a_stack_bank0: assert property (@(posedge clk) disable iff (!resetn)
      stk_we |-> stk_addr[11:8] == 4'h0) // RULE20
      else $error("stack left bank 0");
   a_recov_set: assert property (@(posedge clk) disable iff (!resetn)
      stop_recov |=> recov_flag) // RULE15
      else $error("recovery bit not set");
   a_recov_keep_ptr: assert property (@(posedge clk) disable iff (!resetn)
      stop_recov && !reg_wr |=> $stable(ptr_r)) // RULE14
      else $error("pointer lost on recovery");

   // ----------------------------------------
   // checks on storage, stack frame and mapping
   // ----------------------------------------
   // scratch byte keeps what was written
   a_scratch_store: assert property (@(posedge clk) disable iff (!resetn) // RULE5
      reg_wr && reg_addr == `BRF_ADDR_SCRATCH |=> scratch_r == $past(reg_wdata))
      else $error("scratch byte write lost");
   // accepted stack address write lands
   a_stack_write_idle: assert property (@(posedge clk) disable iff (!resetn) // RULE7
      sp_wr_ok |=> sp_r == $past(reg_wdata))
      else $error("stack address write lost");
   // pointer reads back through the register port
   a_ptr_readback: assert property (@(posedge clk) disable iff (!resetn) // RULE4
      reg_addr == `BRF_ADDR_PTR |=> reg_rdata == $past(ptr_r))
      else $error("pointer read wrong");
   // active pointer moves only at an instruction boundary
   a_ptr_act_hold: assert property (@(posedge clk) disable iff (!resetn) // RULE22
      !insn_start |=> $stable(ptr_act_r))
      else $error("active pointer moved mid instruction");
   // after a call the pointer sits on the last byte written
   a_top_marks_last: assert property (@(posedge clk) disable iff (!resetn) // RULE10
      st_r == brf_pkg::BRF_ST_PUSH_HI && !irq_r |=> stk_ptr == stk_addr[7:0])
      else $error("stack pointer not on last item");
   // first pushed byte is the low program counter byte
   a_call_low_byte: assert property (@(posedge clk) disable iff (!resetn) // RULE11
      st_r == brf_pkg::BRF_ST_PUSH_LO |=> stk_we && stk_wdata == $past(pc_in[7:0]))
      else $error("low counter byte wrong");
   // second pushed byte is the high program counter byte
   a_call_high_byte: assert property (@(posedge clk) disable iff (!resetn) // RULE11
      st_r == brf_pkg::BRF_ST_PUSH_HI |=> stk_we && stk_wdata == $past(pc_in[15:8]))
      else $error("high counter byte wrong");
   // interrupt frame ends with the flags byte
   a_irq_flags_byte: assert property (@(posedge clk) disable iff (!resetn) // RULE12
      st_r == brf_pkg::BRF_ST_FLAGS |=> stk_we && stk_wdata == $past(flags_in))
      else $error("flags byte wrong");
   // working operand takes its group from the upper nibble
   a_work_group_sel: assert property (@(posedge clk) disable iff (!resetn) // RULE1
      op_is_work && op_addr[7:4] != `BRF_WORK_BASE |=> op_lin[7:4] == $past(ptr_act_r[7:4]))
      else $error("working group wrong");
   // bank zero never leaves the first 256 locations
   a_bank0_plain: assert property (@(posedge clk) disable iff (!resetn) // RULE3
      ptr_act_r[3:0] == 4'h0 |=> op_lin[11:8] == 4'h0)
      else $error("bank zero mapped elsewhere");
   // low general registers flagged bank 0 only
   a_bank0_only_regs: assert property (@(posedge clk) disable iff (!resetn) // RULE16
      ptr_act_r[3:0] == 4'h0 && !op_is_work && op_addr >= `BRF_GPR_LO
      && op_addr <= `BRF_GPR_B0_HI |=> op_region == 3'h1)
      else $error("bank 0 only region wrong");
   // middle registers stay in bank 0 for banks 0, d and f
   a_shared_regs: assert property (@(posedge clk) disable iff (!resetn) // RULE17
      (ptr_act_r[3:0] == 4'h0 || ptr_act_r[3:0] == 4'hd || ptr_act_r[3:0] == 4'hf)
      && !op_is_work && op_addr >= 8'h10 && op_addr <= `BRF_GPR_HI
      |=> op_lin == {4'h0, $past(op_addr)})
      else $error("shared registers left bank 0");
   // control addresses reach bank 0 from any bank
   a_ctrl_any_bank: assert property (@(posedge clk) disable iff (!resetn) // RULE18 RULE19
      !op_is_work && op_addr >= `BRF_CTRL_LO
      |=> op_lin == {4'h0, $past(op_addr)} && op_region == 3'h3)
      else $error("control address banked");
   // swapped low registers carry the bank as upper nibble
   a_bank_in_linear: assert property (@(posedge clk) disable iff (!resetn) // RULE21
      !op_is_work && op_addr >= `BRF_GPR_LO && op_addr <= `BRF_GPR_B0_HI
      && ptr_act_r[3:0] != 4'h0 |=> op_lin[11:8] == $past(ptr_act_r[3:0]))
      else $error("bank nibble missing");
   // recovery bit stays set until a full reset
   a_recov_sticky: assert property (@(posedge clk) disable iff (!resetn) // RULE15
      recov_flag |=> recov_flag)
      else $error("recovery bit dropped");
endmodule // brf_top

// ==== brf_stack_ram.sv ====
// bank 0 stack memory model standing in for the core data path
`timescale 1ns/10ps
module brf_stack_ram (
   // clock
   input wire logic clk,
   // write port from the stack sequencer
   input wire logic we,
   input wire logic [11:0] addr,
   input wire logic [7:0] wdata
);
   // whole linear space, so a push into a wrong bank shows up
   logic [7:0] mem [0:4095];
   // -----------------------------
   // capture of pushed bytes
   // -----------------------------
   // store each pushed byte where the sequencer aims it
   always_ff @(posedge clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
   end
endmodule // brf_stack_ram

// ==== brf_top_bench.sv ====
// self-checking bench for the bank pointer and stack block
`timescale 1ns/10ps
module brf_top_bench;
   // -----------------------------
   // signals
   // -----------------------------
   logic clk = 1'b0, resetn = 1'b0, stop_recov = 1'b0, reg_wr = 1'b0;
   logic insn_start = 1'b0, op_is_work = 1'b0;
   logic stk_busy, stk_we, recov_flag;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, op_addr = 8'h00, flags_in = 8'h00;
   logic [7:0] reg_rdata, stk_wdata, stk_ptr;
   logic [11:0] op_lin, stk_addr;
   logic [2:0] op_region;
   logic [15:0] pc_in = 16'h0000;
   brf_pkg::brf_stk_op_t stk_op = brf_pkg::BRF_OP_NONE;
   int fail_count = 0; // mismatches
   int n_checks = 0; // comparisons
   // clock, 50 ns period
   always #25 clk = ~clk;
   brf_top brf_top_i (.clk(clk), .resetn(resetn), .stop_recov(stop_recov),
      .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .insn_start(insn_start), .op_is_work(op_is_work),
      .op_addr(op_addr), .op_lin(op_lin), .op_region(op_region), .stk_op(stk_op),
      .pc_in(pc_in), .flags_in(flags_in), .stk_busy(stk_busy), .stk_we(stk_we),
      .stk_addr(stk_addr), .stk_wdata(stk_wdata), .stk_ptr(stk_ptr),
      .recov_flag(recov_flag));
   brf_stack_ram brf_stack_ram_i (.clk(clk), .we(stk_we), .addr(stk_addr),
      .wdata(stk_wdata));
   // -----------------------------
   // helpers
   // -----------------------------
   // step to just after the next rising edge
   task automatic tick;
      @(posedge clk);
      #5;
   endtask
   // compare and count
   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one-cycle register write
   task automatic reg_write(logic [7:0] a, logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      tick;
      reg_wr = 1'b0;
   endtask
   // present address, read one cycle later
   task automatic reg_read(logic [7:0] a, logic [7:0] exp);
      reg_addr = a;
      tick;
      chk("reg_rdata", {8'h00, exp}, {8'h00, reg_rdata});
   endtask
   // pointer write, optional boundary, then one operand
   task automatic map_chk(logic [7:0] p, logic st, logic w, logic [7:0] a,
      logic [11:0] lin, logic [2:0] rg);
      reg_write(8'hfd, p);
      insn_start = st;
      tick;
      insn_start = 1'b0;
      op_is_work = w;
      op_addr = a;
      tick;
      chk("op_lin", {4'h0, lin}, {4'h0, op_lin});
      chk("op_region", {13'h0, rg}, {13'h0, op_region});
   endtask
   // issue a stack request and wait for the sequence to end
   task automatic stk_req(brf_pkg::brf_stk_op_t o);
      stk_op = o;
      tick;
      stk_op = brf_pkg::BRF_OP_NONE;
      // busy drops one cycle before the last byte lands
      for (int i = 0; i < 10 && (stk_busy !== 1'b0 || stk_we !== 1'b0); i++) tick;
      chk("stk_busy", 16'h0000, {15'h0, stk_busy});
   endtask
   // -----------------------------
   // scenarios
   // -----------------------------
   // pointer and scratch byte access, unmapped read
   task automatic t_regs;
      reg_read(8'hfd, 8'h00);
      reg_write(8'hfd, 8'ha7);
      reg_read(8'hfd, 8'ha7);
      reg_write(8'hfe, 8'h5c);
      reg_read(8'hfe, 8'h5c);
      reg_read(8'h40, 8'h00);
   endtask
   // operand mapping across banks and groups
   task automatic t_map;
      map_chk(8'h00, 1'b1, 1'b0, 8'h08, 12'h008, 3'd1);
      map_chk(8'h03, 1'b1, 1'b0, 8'h08, 12'h308, 3'd4);
      map_chk(8'h0f, 1'b1, 1'b0, 8'h05, 12'hf05, 3'd4);
      map_chk(8'h0d, 1'b1, 1'b0, 8'h40, 12'h040, 3'd2);
      map_chk(8'h02, 1'b1, 1'b0, 8'hf5, 12'h0f5, 3'd3);
      map_chk(8'h01, 1'b1, 1'b1, 8'he5, 12'h0f5, 3'd3);
      map_chk(8'h01, 1'b1, 1'b0, 8'h02, 12'h002, 3'd0);
      map_chk(8'h05, 1'b1, 1'b0, 8'h20, 12'h520, 3'd5);
      map_chk(8'h70, 1'b1, 1'b1, 8'h05, 12'h075, 3'd2);
      // new pointer not yet applied: old active 70 still maps bank 0
      map_chk(8'h03, 1'b0, 1'b0, 8'h08, 12'h008, 3'd1);
   endtask
   // call, interrupt and pop; stack kept far from wrap
   task automatic t_stack;
      reg_write(8'hff, 8'h80);
      pc_in = 16'h1234;
      stk_op = brf_pkg::BRF_OP_CALL;
      tick;
      stk_op = brf_pkg::BRF_OP_NONE;
      reg_write(8'hff, 8'h00); // refused while busy
      stk_req(brf_pkg::BRF_OP_NONE);
      chk("stk_ptr", 16'h007e, {8'h0, stk_ptr});
      chk("ram 07f", 16'h0034, {8'h0, brf_stack_ram_i.mem[12'h07f]});
      chk("ram 07e", 16'h0012, {8'h0, brf_stack_ram_i.mem[12'h07e]});
      reg_read(8'hff, 8'h7e);
      pc_in = 16'h5678;
      flags_in = 8'ha5;
      stk_req(brf_pkg::BRF_OP_IRQ);
      chk("ram 07d", 16'h0078, {8'h0, brf_stack_ram_i.mem[12'h07d]});
      chk("ram 07c", 16'h0056, {8'h0, brf_stack_ram_i.mem[12'h07c]});
      chk("ram 07b", 16'h00a5, {8'h0, brf_stack_ram_i.mem[12'h07b]});
      stk_op = brf_pkg::BRF_OP_POP;
      tick;
      stk_op = brf_pkg::BRF_OP_NONE;
      chk("pop addr", 16'h007b, {4'h0, stk_addr});
      chk("pop ptr", 16'h007c, {8'h0, stk_ptr});
   endtask
   // stop recovery flag, then a second full reset
   task automatic t_recov;
      stop_recov = 1'b1;
      tick;
      stop_recov = 1'b0;
      tick;
      chk("recov_flag", 16'h0001, {15'h0, recov_flag});
      reg_read(8'hfd, 8'h03);
      resetn = 1'b0;
      tick;
      chk("recov_flag", 16'h0000, {15'h0, recov_flag});
      resetn = 1'b1;
      reg_read(8'hfd, 8'h00);
   endtask
   // -----------------------------
   // verdict and run
   // -----------------------------
   // report counts, print verdict, end
   task automatic stop_test;
      $display("checks %0d errors %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // watchdog, far beyond the few dozen cycles needed
   initial begin
      #100000;
      fail_count++;
      stop_test;
   end
   // main sequence; scratch byte never used as loop count
   initial begin
      repeat (3) tick;
      resetn = 1'b1;
      t_regs;
      t_map;
      t_stack;
      t_recov;
      stop_test;
   end
endmodule // brf_top_bench
